// ==== design/ossc_defs.svh ====
// register offsets, field positions, reset values and source codes for output source select
`ifndef OSSC_DEFS_SVH
`define OSSC_DEFS_SVH
`define OSSC_ADDR_SEL0      8'h1C
`define OSSC_ADDR_SPARE     8'h1D
`define OSSC_ADDR_SEL1      8'h1E
`define OSSC_RST_SEL0       8'h58
`define OSSC_RST_SPARE      8'h00
`define OSSC_RST_SEL1       8'h09
`define OSSC_CODE_MSB       7
`define OSSC_CODE_LSB       5
`define OSSC_PICK_BIT       4
`define OSSC_POL_MSB        3
`define OSSC_POL_LSB        2
// first output codes
`define OSSC_O0_MUTE        3'h0
`define OSSC_O0_CLK10       3'h1
`define OSSC_O0_RAW         3'h2
`define OSSC_O0_RETIMED     3'h4
// second output codes
`define OSSC_O1_RAW         3'h0
`define OSSC_O1_RETIMED     3'h1
`define OSSC_O1_VCO         3'h2
`define OSSC_O1_CLKSEL      3'h5
`define OSSC_O1_MUTE        3'h7
// pair policy codes
`define OSSC_POL_MUTE       2'h0
`define OSSC_POL_CLOCK      2'h1
`define OSSC_POL_RETIME     2'h2
`define OSSC_POL_RAW        2'h3
`endif

// ==== design/ossc_pkg.sv ====
// types shared by the output source select block
package ossc_pkg;
  typedef enum logic [5:0] {
    OSSC_SRC_MUTE    = 6'h01,
    OSSC_SRC_RAW     = 6'h02,
    OSSC_SRC_RETIMED = 6'h04,
    OSSC_SRC_VCO     = 6'h08,
    OSSC_SRC_VCO40   = 6'h10,
    OSSC_SRC_CLK10   = 6'h20
  } ossc_src_e;

  typedef struct packed {
    logic       wrEn;
    logic       rdEn;
    logic [7:0] addr;
    logic [7:0] wrData;
  } ossc_req_s;

  typedef struct packed {
    logic [2:0] firstCode;
    logic [2:0] secondCode;
  } ossc_codes_s;
endpackage : ossc_pkg

// ==== design/ossc_policy.sv ====
// combinational pair-policy decoder: lock state and rate to applied source codes
`timescale 1ns/1ps
`include "ossc_defs.svh"
module ossc_policy (
  input  wire logic [1:0]          policy,
  input  wire logic                cdrLocked,
  input  wire logic                rateAbove3g,
  output ossc_pkg::ossc_codes_s    codes
);
  always_comb begin
    codes = '{firstCode: `OSSC_O0_MUTE, secondCode: `OSSC_O1_MUTE};
    unique case (policy)
      `OSSC_POL_MUTE: begin
        codes = '{firstCode: `OSSC_O0_MUTE, secondCode: `OSSC_O1_MUTE};
      end
      `OSSC_POL_CLOCK: begin
        if (cdrLocked) begin
          codes.firstCode  = `OSSC_O0_RETIMED;
          codes.secondCode = rateAbove3g ? `OSSC_O1_CLKSEL : `OSSC_O1_VCO;
        end else begin
          codes = '{firstCode: `OSSC_O0_RAW, secondCode: `OSSC_O1_MUTE};
        end
      end
      `OSSC_POL_RETIME: begin
        if (cdrLocked) begin
          codes = '{firstCode: `OSSC_O0_RETIMED, secondCode: `OSSC_O1_RETIMED};
        end else begin
          codes = '{firstCode: `OSSC_O0_RAW, secondCode: `OSSC_O1_RAW};
        end
      end
      `OSSC_POL_RAW: begin
        codes = '{firstCode: `OSSC_O0_RAW, secondCode: `OSSC_O1_RAW};
      end
    endcase
  end
endmodule : ossc_policy

// ==== design/ossc_top.sv ====
// output source select control: registers, policy, override and applied sources
// Behaviour
// - first select field reads back the code applied to the first output
// - with mux override, first output follows its select code
// - with override and second code 101, pick bit chooses 10 MHz or VCO/40
// - with pin override, register policy field replaces the policy pin
// - policy 00 mutes both outputs regardless of lock
// - policy 01 locked gives retimed data first, recovered clock second
// - policy 01 locked clock is VCO up to 3G, VCO/40 above
// - policy 01 unlocked gives raw first, second muted
// - policy 10 retimed both when locked, raw both unlocked; default policy
// - policy 11 gives raw data on both outputs
// - second select field reads back the code applied to the second output
// - with mux override, second output follows its select code
// - second code 101 gives 10 MHz when pick is 0, VCO/40 when 1
`timescale 1ns/1ps
`include "ossc_defs.svh"
module ossc_top (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire ossc_pkg::ossc_req_s  req,
  input  wire logic                 policyPin0,
  input  wire logic                 policyPin1,
  input  wire logic                 muxOverride,
  input  wire logic                 pinOverride,
  input  wire logic                 cdrLocked,
  input  wire logic                 rateAbove3g,
  output ossc_pkg::ossc_src_e       firstSerialOutputSrc_q,
  output ossc_pkg::ossc_src_e       secondSerialOutputSrc_q,
  output logic [7:0]                rdData_q,
  output logic                      rdValid_q,
  output logic                      codeInvalid_q
);
  // stored register bytes; code fields hold the last written value
  logic [7:0]             sel0_q;
  logic [7:0]             sel0_d;
  logic [7:0]             spare_q;
  logic [7:0]             spare_d;
  logic [7:0]             sel1_q;
  logic [7:0]             sel1_d;
  logic [1:0]             policy;
  ossc_pkg::ossc_codes_s  polCodes;
  ossc_pkg::ossc_codes_s  applied;
  ossc_pkg::ossc_src_e    firstSrc_d;
  ossc_pkg::ossc_src_e    secondSrc_d;
  logic [7:0]             rdData_d;
  logic                   rdValid_d;
  logic                   codeInvalid_d;

  function automatic ossc_pkg::ossc_src_e firstSrc(input logic [2:0] code);
    unique case (code)
      `OSSC_O0_MUTE:    firstSrc = ossc_pkg::OSSC_SRC_MUTE;
      `OSSC_O0_CLK10:   firstSrc = ossc_pkg::OSSC_SRC_CLK10;
      `OSSC_O0_RAW:     firstSrc = ossc_pkg::OSSC_SRC_RAW;
      `OSSC_O0_RETIMED: firstSrc = ossc_pkg::OSSC_SRC_RETIMED;
      default:          firstSrc = ossc_pkg::OSSC_SRC_MUTE;
    endcase
  endfunction : firstSrc

  function automatic ossc_pkg::ossc_src_e secondSrc(input logic [2:0] code,
                                                    input logic       pick);
    unique case (code)
      `OSSC_O1_RAW:     secondSrc = ossc_pkg::OSSC_SRC_RAW;
      `OSSC_O1_RETIMED: secondSrc = ossc_pkg::OSSC_SRC_RETIMED;
      `OSSC_O1_VCO:     secondSrc = ossc_pkg::OSSC_SRC_VCO;
      `OSSC_O1_CLKSEL:  secondSrc = pick ? ossc_pkg::OSSC_SRC_VCO40 : ossc_pkg::OSSC_SRC_CLK10;
      `OSSC_O1_MUTE:    secondSrc = ossc_pkg::OSSC_SRC_MUTE;
      default:          secondSrc = ossc_pkg::OSSC_SRC_MUTE;
    endcase
  endfunction : secondSrc

  function automatic logic firstValid(input logic [2:0] code);
    firstValid = (code == `OSSC_O0_MUTE) || (code == `OSSC_O0_CLK10) ||
                 (code == `OSSC_O0_RAW) || (code == `OSSC_O0_RETIMED);
  endfunction : firstValid

  function automatic logic secondValid(input logic [2:0] code);
    secondValid = (code == `OSSC_O1_RAW) || (code == `OSSC_O1_RETIMED) ||
                  (code == `OSSC_O1_VCO) || (code == `OSSC_O1_CLKSEL) ||
                  (code == `OSSC_O1_MUTE);
  endfunction : secondValid

  assign policy = pinOverride ? sel0_q[`OSSC_POL_MSB:`OSSC_POL_LSB]
                              : {policyPin1, policyPin0};

  ossc_policy uPolicy (
    .policy      (policy),
    .cdrLocked   (cdrLocked),
    .rateAbove3g (rateAbove3g),
    .codes       (polCodes)
  );

  always_comb begin
    applied = polCodes;
    if (muxOverride) begin
      applied.firstCode  = sel0_q[`OSSC_CODE_MSB:`OSSC_CODE_LSB];
      applied.secondCode = sel1_q[`OSSC_CODE_MSB:`OSSC_CODE_LSB];
    end
  end

  // register writes; all bits writable, reserved bits simply store
  always_comb begin
    sel0_d  = sel0_q;
    spare_d = spare_q;
    sel1_d  = sel1_q;
    if (req.wrEn) begin
      unique case (req.addr)
        `OSSC_ADDR_SEL0:  sel0_d  = req.wrData;
        `OSSC_ADDR_SPARE: spare_d = req.wrData;
        `OSSC_ADDR_SEL1:  sel1_d  = req.wrData;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sel0_q  <= `OSSC_RST_SEL0;
      spare_q <= `OSSC_RST_SPARE;
      sel1_q  <= `OSSC_RST_SEL1;
    end else begin
      sel0_q  <= sel0_d;
      spare_q <= spare_d;
      sel1_q  <= sel1_d;
    end
  end

  // second clock from rate via pick
  // policy 01 above 3G lands on code 101 with pick forced to VCO/40
  always_comb begin
    firstSrc_d  = firstSrc(applied.firstCode);
    secondSrc_d = secondSrc(applied.secondCode,
                            muxOverride ? sel0_q[`OSSC_PICK_BIT] : 1'b1);
    // invalid codes are flagged and muted rather than left undefined
    codeInvalid_d = muxOverride &&
                    (!firstValid(applied.firstCode) || !secondValid(applied.secondCode));
  end

  // reads: code fields return the applied selection, other bits as stored
  always_comb begin
    rdValid_d = req.rdEn;
    rdData_d  = 8'h00;
    if (req.rdEn) begin
      unique case (req.addr)
        `OSSC_ADDR_SEL0:  rdData_d = {applied.firstCode, sel0_q[4:0]};
        `OSSC_ADDR_SPARE: rdData_d = spare_q;
        `OSSC_ADDR_SEL1:  rdData_d = {applied.secondCode, sel1_q[4:0]};
        default:          rdData_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      firstSerialOutputSrc_q  <= ossc_pkg::OSSC_SRC_MUTE;
      secondSerialOutputSrc_q <= ossc_pkg::OSSC_SRC_MUTE;
      rdData_q                <= 8'h00;
      rdValid_q               <= 1'b0;
      codeInvalid_q           <= 1'b0;
    end else begin
      firstSerialOutputSrc_q  <= firstSrc_d;
      secondSerialOutputSrc_q <= secondSrc_d;
      rdData_q                <= rdData_d;
      rdValid_q               <= rdValid_d;
      codeInvalid_q           <= codeInvalid_d;
    end
  end

  // checks
  logic [1:0] effPol;
  assign effPol = pinOverride ? sel0_q[3:2] : {policyPin1, policyPin0};

  mute_both_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!muxOverride && effPol == 2'h0) |=> firstSerialOutputSrc_q == ossc_pkg::OSSC_SRC_MUTE &&
      secondSerialOutputSrc_q == ossc_pkg::OSSC_SRC_MUTE)
    else $error("policy 00 did not mute both outputs");

  clock_locked_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!muxOverride && effPol == 2'h1 && cdrLocked) |=>
      firstSerialOutputSrc_q == ossc_pkg::OSSC_SRC_RETIMED)
    else $error("policy 01 locked first output not retimed");

  clock_rate_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!muxOverride && effPol == 2'h1 && cdrLocked) |=> secondSerialOutputSrc_q ==
      ($past(rateAbove3g) ? ossc_pkg::OSSC_SRC_VCO40 : ossc_pkg::OSSC_SRC_VCO))
    else $error("policy 01 second clock wrong for rate");

  clock_unlock_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!muxOverride && effPol == 2'h1 && !cdrLocked) |=>
      firstSerialOutputSrc_q == ossc_pkg::OSSC_SRC_RAW &&
      secondSerialOutputSrc_q == ossc_pkg::OSSC_SRC_MUTE)
    else $error("policy 01 unlocked sources wrong");

  retime_pol_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!muxOverride && effPol == 2'h2) |=> secondSerialOutputSrc_q ==
      ($past(cdrLocked) ? ossc_pkg::OSSC_SRC_RETIMED : ossc_pkg::OSSC_SRC_RAW))
    else $error("policy 10 second output wrong");

  raw_pol_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!muxOverride && effPol == 2'h3) |=> firstSerialOutputSrc_q == ossc_pkg::OSSC_SRC_RAW &&
      secondSerialOutputSrc_q == ossc_pkg::OSSC_SRC_RAW)
    else $error("policy 11 not raw on both");

  override_first_a: assert property (@(posedge clk) disable iff (!rst_n)
    (muxOverride && sel0_q[7:5] == 3'h4) |=> firstSerialOutputSrc_q == ossc_pkg::OSSC_SRC_RETIMED)
    else $error("override first code 100 not retimed");

  override_pick_a: assert property (@(posedge clk) disable iff (!rst_n)
    (muxOverride && sel1_q[7:5] == 3'h5) |=> secondSerialOutputSrc_q ==
      ($past(sel0_q[4]) ? ossc_pkg::OSSC_SRC_VCO40 : ossc_pkg::OSSC_SRC_CLK10))
    else $error("code 101 clock pick wrong");

  readback_first_a: assert property (@(posedge clk) disable iff (!rst_n)
    (req.rdEn && req.addr == 8'h1C && !muxOverride) |=> rdData_q[7:5] ==
      $past(polCodes.firstCode))
    else $error("first field readback not applied code");

  readback_second_a: assert property (@(posedge clk) disable iff (!rst_n)
    (req.rdEn && req.addr == 8'h1E) |=> rdData_q[7:5] == ($past(muxOverride) ?
      $past(sel1_q[7:5]) : $past(polCodes.secondCode)))
    else $error("second field readback not applied code");

  readback_override_a: assert property (@(posedge clk) disable iff (!rst_n)
    (req.rdEn && req.addr == `OSSC_ADDR_SEL0 && muxOverride) |=>
      rdData_q[7:5] == $past(sel0_q[7:5]))
    else $error("first field readback under override not written code");

  read_valid_a: assert property (@(posedge clk) disable iff (!rst_n)
    req.rdEn |=> rdValid_q)
    else $error("read not answered one cycle later");

  retime_first_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!muxOverride && effPol == `OSSC_POL_RETIME) |=> firstSerialOutputSrc_q ==
      ($past(cdrLocked) ? ossc_pkg::OSSC_SRC_RETIMED : ossc_pkg::OSSC_SRC_RAW))
    else $error("policy 10 first output wrong");

  // register policy 00 must win over the pins whenever the pin override is set and the mux override is clear
  pin_policy_a: assert property (@(posedge clk) disable iff (!rst_n)
    (pinOverride && !muxOverride && sel0_q[3:2] == `OSSC_POL_MUTE) |=>
      firstSerialOutputSrc_q == ossc_pkg::OSSC_SRC_MUTE &&
      secondSerialOutputSrc_q == ossc_pkg::OSSC_SRC_MUTE)
    else $error("register policy 00 did not replace the pins");

  pin_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!pinOverride && !muxOverride && {policyPin1, policyPin0} == `OSSC_POL_RAW) |=>
      firstSerialOutputSrc_q == ossc_pkg::OSSC_SRC_RAW &&
      secondSerialOutputSrc_q == ossc_pkg::OSSC_SRC_RAW)
    else $error("pin policy 11 not followed");

  // override path: every documented code except first 100 and second 101 (checked above) lands on its own source
  override_mute_first_a: assert property (@(posedge clk) disable iff (!rst_n)
    (muxOverride && sel0_q[7:5] == `OSSC_O0_MUTE) |=>
      firstSerialOutputSrc_q == ossc_pkg::OSSC_SRC_MUTE)
    else $error("override first code 000 not muted");

  override_clk10_first_a: assert property (@(posedge clk) disable iff (!rst_n)
    (muxOverride && sel0_q[7:5] == `OSSC_O0_CLK10) |=>
      firstSerialOutputSrc_q == ossc_pkg::OSSC_SRC_CLK10)
    else $error("override first code 001 not 10 MHz clock");

  override_raw_first_a: assert property (@(posedge clk) disable iff (!rst_n)
    (muxOverride && sel0_q[7:5] == `OSSC_O0_RAW) |=>
      firstSerialOutputSrc_q == ossc_pkg::OSSC_SRC_RAW)
    else $error("override first code 010 not raw");

  override_raw_second_a: assert property (@(posedge clk) disable iff (!rst_n)
    (muxOverride && sel1_q[7:5] == `OSSC_O1_RAW) |=>
      secondSerialOutputSrc_q == ossc_pkg::OSSC_SRC_RAW)
    else $error("override second code 000 not raw");

  override_retimed_second_a: assert property (@(posedge clk) disable iff (!rst_n)
    (muxOverride && sel1_q[7:5] == `OSSC_O1_RETIMED) |=>
      secondSerialOutputSrc_q == ossc_pkg::OSSC_SRC_RETIMED)
    else $error("override second code 001 not retimed");

  override_vco_a: assert property (@(posedge clk) disable iff (!rst_n)
    (muxOverride && sel1_q[7:5] == `OSSC_O1_VCO) |=>
      secondSerialOutputSrc_q == ossc_pkg::OSSC_SRC_VCO)
    else $error("override second code 010 not full rate clock");

  override_mute_second_a: assert property (@(posedge clk) disable iff (!rst_n)
    (muxOverride && sel1_q[7:5] == `OSSC_O1_MUTE) |=>
      secondSerialOutputSrc_q == ossc_pkg::OSSC_SRC_MUTE)
    else $error("override second code 111 not muted");

  cov_locked_c: cover property (@(posedge clk) disable iff (!rst_n)
    !muxOverride && effPol == 2'h1 && cdrLocked && rateAbove3g);
  cov_override_c: cover property (@(posedge clk) disable iff (!rst_n)
    muxOverride && sel1_q[7:5] == 3'h5 && sel0_q[4]);
  cov_unlock_c: cover property (@(posedge clk) disable iff (!rst_n)
    !muxOverride && effPol == 2'h2 && !cdrLocked);
  cov_pin_mute_c: cover property (@(posedge clk) disable iff (!rst_n)
    pinOverride && !muxOverride && sel0_q[3:2] == `OSSC_POL_MUTE);
  cov_pins_raw_c: cover property (@(posedge clk) disable iff (!rst_n)
    !pinOverride && !muxOverride && {policyPin1, policyPin0} == `OSSC_POL_RAW);
endmodule : ossc_top

// ==== dv/tb_top.sv ====
// self-checking testbench for the output source select control
`timescale 1ns/1ps
`include "ossc_defs.svh"
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin n_fail++; \
  $display("mismatch %s expected %0h seen %0h", nm, ex, got); end end
module tb_top;
  logic                 clk;
  logic                 rst_n;
  ossc_pkg::ossc_req_s  req;
  logic                 policyPin0;
  logic                 policyPin1;
  logic                 muxOverride;
  logic                 pinOverride;
  logic                 cdrLocked;
  logic                 rateAbove3g;
  ossc_pkg::ossc_src_e  firstSrc;
  ossc_pkg::ossc_src_e  secondSrc;
  logic [7:0]           rdData;
  logic                 rdValid;
  logic                 codeInvalid;
  int                   n_fail;
  int                   tests_run;
  logic [2:0]           codes0 [4] = '{3'h0, 3'h1, 3'h2, 3'h4};
  logic [2:0]           codes1 [4] = '{3'h0, 3'h1, 3'h2, 3'h7};

  ossc_top ossc_top_i (
    .clk                     (clk),
    .rst_n                   (rst_n),
    .req                     (req),
    .policyPin0              (policyPin0),
    .policyPin1              (policyPin1),
    .muxOverride             (muxOverride),
    .pinOverride             (pinOverride),
    .cdrLocked               (cdrLocked),
    .rateAbove3g             (rateAbove3g),
    .firstSerialOutputSrc_q  (firstSrc),
    .secondSerialOutputSrc_q (secondSrc),
    .rdData_q                (rdData),
    .rdValid_q               (rdValid),
    .codeInvalid_q           (codeInvalid)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  function automatic ossc_pkg::ossc_src_e src0(input logic [2:0] c);
    case (c)
      `OSSC_O0_CLK10:   return ossc_pkg::OSSC_SRC_CLK10;
      `OSSC_O0_RAW:     return ossc_pkg::OSSC_SRC_RAW;
      `OSSC_O0_RETIMED: return ossc_pkg::OSSC_SRC_RETIMED;
      default:          return ossc_pkg::OSSC_SRC_MUTE;
    endcase
  endfunction : src0

  function automatic ossc_pkg::ossc_src_e src1(input logic [2:0] c, input logic pk);
    case (c)
      `OSSC_O1_RAW:     return ossc_pkg::OSSC_SRC_RAW;
      `OSSC_O1_RETIMED: return ossc_pkg::OSSC_SRC_RETIMED;
      `OSSC_O1_VCO:     return ossc_pkg::OSSC_SRC_VCO;
      `OSSC_O1_CLKSEL:  return pk ? ossc_pkg::OSSC_SRC_VCO40 : ossc_pkg::OSSC_SRC_CLK10;
      default:          return ossc_pkg::OSSC_SRC_MUTE;
    endcase
  endfunction : src1

  // expected {first code, second code} for a pair policy
  function automatic logic [5:0] polCodes(input logic [1:0] p, input logic lk, input logic rt);
    case (p)
      2'h0:    return 6'h07;
      2'h1:    return lk ? {3'h4, (rt ? 3'h5 : 3'h2)} : 6'h17;
      2'h2:    return lk ? 6'h21 : 6'h10;
      default: return 6'h10;
    endcase
  endfunction : polCodes

  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask : settle

  task automatic regWrite(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{wrEn: 1'b1, rdEn: 1'b0, addr: a, wrData: d};
    @(posedge clk);
    req.wrEn <= 1'b0;
  endtask : regWrite

  task automatic regCheck(input string nm, input logic [7:0] a, input logic [7:0] ex);
    @(posedge clk);
    req <= '{wrEn: 1'b0, rdEn: 1'b1, addr: a, wrData: 8'h00};
    @(posedge clk);
    req.rdEn <= 1'b0;
    #1;
    `CHK("read valid", 1'b1, rdValid)
    `CHK(nm, ex, rdData)
  endtask : regCheck

  task automatic scen_reset;
    settle();
    `CHK("first src", ossc_pkg::OSSC_SRC_RAW, firstSrc)
    `CHK("second src", ossc_pkg::OSSC_SRC_RAW, secondSrc)
    regCheck("sel0 reset", 8'h1C, 8'h58);
    regCheck("spare reset", 8'h1D, 8'h00);
    regCheck("sel1 reset", 8'h1E, 8'h09);
    regWrite(8'h20, 8'hFF);
    regCheck("unmapped", 8'h20, 8'h00);
  endtask : scen_reset

  task automatic scen_policy;
    logic [5:0] ex;
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      pinOverride <= 1'b0;
      {policyPin1, policyPin0} <= i[3:2];
      cdrLocked <= i[1];
      rateAbove3g <= i[0];
      settle();
      ex = polCodes(i[3:2], i[1], i[0]);
      `CHK("pol first", src0(ex[5:3]), firstSrc)
      `CHK("pol second", src1(ex[2:0], 1'b1), secondSrc)
      regCheck("pol sel0", 8'h1C, {ex[5:3], 5'h18});
      regCheck("pol sel1", 8'h1E, {ex[2:0], 5'h09});
    end
  endtask : scen_policy

  task automatic scen_pinover;
    @(posedge clk);
    pinOverride <= 1'b1;
    {policyPin1, policyPin0} <= 2'h3;
    cdrLocked <= 1'b1;
    regWrite(8'h1C, 8'h50);
    settle();
    `CHK("ovr mute", ossc_pkg::OSSC_SRC_MUTE, secondSrc)
    regWrite(8'h1C, 8'h58);
    settle();
    `CHK("ovr retimed", ossc_pkg::OSSC_SRC_RETIMED, firstSrc)
  endtask : scen_pinover

  task automatic scen_mux;
    @(posedge clk);
    muxOverride <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      regWrite(8'h1C, {codes0[i], 5'h18});
      regWrite(8'h1E, {codes1[i], 5'h09});
      settle();
      `CHK("mux first", src0(codes0[i]), firstSrc)
      `CHK("mux second", src1(codes1[i], 1'b1), secondSrc)
      regCheck("mux sel0", 8'h1C, {codes0[i], 5'h18});
      regCheck("mux sel1", 8'h1E, {codes1[i], 5'h09});
    end
    regWrite(8'h1E, 8'hA9);
    for (int k = 0; k < 2; k++) begin
      regWrite(8'h1C, {3'h4, k[0], 4'h8});
      settle();
      `CHK("pick", src1(3'h5, k[0]), secondSrc)
    end
    regWrite(8'h1C, 8'h58);
    settle();
    `CHK("good code", 1'b0, codeInvalid)
    @(posedge clk);
    muxOverride <= 1'b0;
    // code 011 is written only while the mux override is clear
    regWrite(8'h1C, 8'h78);
    settle();
    `CHK("bad code", 1'b0, codeInvalid)
    `CHK("bad ignored", ossc_pkg::OSSC_SRC_RETIMED, firstSrc)
    regCheck("bad read", 8'h1C, 8'h98);
    regWrite(8'h1C, 8'h58);
  endtask : scen_mux

  task automatic end_of_test;
    if (n_fail == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test

  initial begin
    n_fail = 0;
    tests_run = 0;
    rst_n = 1'b0;
    req = '0;
    {policyPin1, policyPin0} = 2'h0;
    muxOverride = 1'b0;
    pinOverride = 1'b1;
    cdrLocked = 1'b0;
    rateAbove3g = 1'b0;
    repeat (10) @(posedge clk);
    #1;
    `CHK("reset src", ossc_pkg::OSSC_SRC_MUTE, firstSrc)
    @(posedge clk);
    rst_n <= 1'b1;
    scen_reset();
    scen_policy();
    scen_pinover();
    scen_mux();
    end_of_test();
  end

  // the whole run needs well under 1000 cycles
  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    end_of_test();
  end
endmodule : tb_top
